// ==== src/plced_pkg.sv ====
// Purpose: constants for the error detection and dispatch unit
// Assumes: 25 MHz clock, 20-bit system addresses
// Notes: event index order is the dispatch priority (0 first)
// How it works
// - absent data block: handler, else halt
// - missing data block clears start, length
// - fault type 0101H logic, 0904H data
// - missing ready acknowledge raises bus timeout
// - direct access timeout: handler, else continue
// - image or flag timeout: handler, else continue
// - interrupt byte timeout: handler, else halt
// - distributed range timeout: handler, else continue
// - timeout address kept high/low words
// - unassigned image access completes, then faults
// - addressing fault: handler then resume, else halt
// - check off/on instructions gate addressing faults
// - cycle measured between main block starts
// - overrun: handler, restart; repeat or absent halts
// - limit 10..2550 ms, default 200 ms
// - retrigger call restarts monitor, no fault
// - bad substitution or opcode: handler, else halt
// - opening block 0 or 1 is substitution
// - parity mismatch: handler, else halt
// - user memory timeout behaves as parity fault
// - system RAM parity forces hard halt
// - parity address kept high/low words
// - nested faults served in call order
// - over five nested handlers: hard halt
package plced_pkg;
  // ==========================================================
  // register map
  localparam logic [19:0] REG_BUS_TO_HI = 20'hEF044;
  localparam logic [19:0] REG_BUS_TO_LO = 20'hEF045;
  localparam logic [19:0] REG_PAR_HI = 20'hEF046;
  localparam logic [19:0] REG_PAR_LO = 20'hEF047;
  localparam logic [19:0] REG_FAULT_TYPE = 20'hEF04B;
  localparam logic [19:0] REG_HANDLER_EN = 20'hEF0F0;
  localparam logic [19:0] REG_CYCLE_LIMIT = 20'hEF0F1;
  localparam logic [19:0] REG_STATUS = 20'hEF0F2;
  localparam logic [15:0] TYPE_LOGIC_MISSING = 16'h0101;
  localparam logic [15:0] TYPE_DATA_MISSING = 16'h0904;
  // ==========================================================
  // distributed peripheral windows
  localparam logic [19:0] DIST_A_LO = 20'hF0000;
  localparam logic [19:0] DIST_A_HI = 20'hFEFFF;
  localparam logic [19:0] DIST_B_LO = 20'hFF200;
  // ==========================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int ACK_TIMEOUT_NS = 1600;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_NS;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [7:0] CYCLE_UNIT_MS = 8'h0A;
  localparam logic [7:0] CYCLE_DEFAULT = 8'h14;
  localparam logic [2:0] MAX_NEST = 3'h5;
  // ==========================================================
  // events, index = priority
  localparam int NEV = 10;
  localparam int EV_PARITY = 0;
  localparam int EV_CYCLE = 1;
  localparam int EV_SUBST = 2;
  localparam int EV_INTBYTE = 3;
  localparam int EV_ADDR = 4;
  localparam int EV_DATABLK = 5;
  localparam int EV_LOGICBLK = 6;
  localparam int EV_DIRECT = 7;
  localparam int EV_IMAGE = 8;
  localparam int EV_DIST = 9;
  localparam logic [9:0] HALT_IF_ABSENT = 10'h03F;
  localparam logic [7:0] HANDLER_NUM [NEV] = '{8'h1E, 8'h1A, 8'h1B, 8'h1C, 8'h19,
                                               8'h13, 8'h13, 8'h17, 8'h18, 8'h1D};
  // access kinds
  typedef enum logic [1:0] {ACC_DIRECT, ACC_IMAGE, ACC_INTBYTE, ACC_USERMEM} plced_acc_e;
endpackage : plced_pkg

// ==== src/plced_error_dispatch.sv ====
// Purpose: detect CPU faults and dispatch handler calls or halts
// Assumes: event inputs are one-cycle pulses from the CPU core
// Notes: one handler call is issued per cycle at most
module plced_error_dispatch import plced_pkg::*; #(
  parameter int CYCLES_PER_MS = CYC_PER_MS,
  parameter int ACK_CYCLES = ACK_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [19:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // block open and call
  input wire logic blockOpen,
  input wire logic blockIsExt,
  input wire logic [7:0] blockNum,
  input wire logic blockExists,
  input wire logic blockValid,
  input wire logic logicCallMissing,
  output logic blockRegsClear,
  // backplane access
  input wire logic accStart,
  input wire logic [19:0] accAddr,
  input wire logic [1:0] accKind,
  input wire logic busReady,
  output logic accTimeout,
  // image, opcode, parity
  input wire logic imageAccessDone,
  input wire logic imageAssigned,
  input wire logic addrCheckOff,
  input wire logic addrCheckOn,
  input wire logic illegalSubst,
  input wire logic illegalOpcode,
  input wire logic memParityErr,
  input wire logic memParityOsRam,
  input wire logic [19:0] memParityAddr,
  // cycle control
  input wire logic mainCycleStart,
  input wire logic cycleRetrigger,
  // handler control
  input wire logic handlerDone,
  output logic handlerCall,
  output logic [7:0] handlerNum,
  output logic [2:0] nestDepth,
  output logic halted,
  output logic hardHalted
);
  // ==========================================================
  // register file
  logic [15:0] busHi_q, busHi_d, busLo_q, busLo_d;
  logic [15:0] parHi_q, parHi_d, parLo_q, parLo_d;
  logic [15:0] ftype_q, ftype_d;
  logic [9:0] hEn_q, hEn_d;
  logic [7:0] cycLim_q, cycLim_d;
  logic [15:0] rdata_d;
  logic chkOn_q, chkOn_d;
  logic busTo, busToMem;
  logic [19:0] accAddr_q;

  always_comb begin
    busHi_d = busHi_q;
    busLo_d = busLo_q;
    parHi_d = parHi_q;
    parLo_d = parLo_q;
    ftype_d = ftype_q;
    hEn_d = hEn_q;
    cycLim_d = cycLim_q;
    chkOn_d = chkOn_q;
    // only handler enable and cycle limit are writable; capture words ignore writes
    if (regWr && regAddr == REG_HANDLER_EN) begin
      hEn_d = regWdata[9:0];
    end
    if (regWr && regAddr == REG_CYCLE_LIMIT) begin
      cycLim_d = regWdata[7:0];
    end
    if (addrCheckOff) begin
      chkOn_d = 1'b0;
    end
    if (addrCheckOn) begin
      chkOn_d = 1'b1;
    end
    if (busTo && !busToMem) begin
      busHi_d = {12'h000, accAddr_q[19:16]};
      busLo_d = accAddr_q[15:0];
    end
    if (busTo && busToMem) begin
      parHi_d = {12'h000, accAddr_q[19:16]};
      parLo_d = accAddr_q[15:0];
    end else if (memParityErr) begin
      parHi_d = {12'h000, memParityAddr[19:16]};
      parLo_d = memParityAddr[15:0];
    end
    if (logicCallMissing) begin
      ftype_d = TYPE_LOGIC_MISSING;
    end
    if (blockOpen && !(blockNum < 8'h02 && !blockIsExt) && !(blockExists && blockValid)) begin
      ftype_d = TYPE_DATA_MISSING;
    end
    // read data stand one cycle, then fall back to zero
    rdata_d = 16'h0000;
    if (regRd) begin
      case (regAddr)
        REG_BUS_TO_HI: rdata_d = busHi_q;
        REG_BUS_TO_LO: rdata_d = busLo_q;
        REG_PAR_HI: rdata_d = parHi_q;
        REG_PAR_LO: rdata_d = parLo_q;
        REG_FAULT_TYPE: rdata_d = ftype_q;
        REG_HANDLER_EN: rdata_d = {6'h00, hEn_q};
        REG_CYCLE_LIMIT: rdata_d = {8'h00, cycLim_q};
        REG_STATUS: rdata_d = {10'h000, nestDepth, chkOn_q, hardHalted, halted};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busHi_q <= 16'h0000;
      busLo_q <= 16'h0000;
      parHi_q <= 16'h0000;
      parLo_q <= 16'h0000;
      ftype_q <= 16'h0000;
      hEn_q <= 10'h000;
      cycLim_q <= 8'h00;
      chkOn_q <= 1'b1;
      regRdata <= 16'h0000;
    end else begin
      busHi_q <= busHi_d;
      busLo_q <= busLo_d;
      parHi_q <= parHi_d;
      parLo_q <= parLo_d;
      ftype_q <= ftype_d;
      hEn_q <= hEn_d;
      cycLim_q <= cycLim_d;
      chkOn_q <= chkOn_d;
      regRdata <= rdata_d;
    end
  end

  // ==========================================================
  // acknowledge watchdog
  logic accBusy_q, accBusy_d;
  logic [1:0] accKind_q, accKind_d;
  logic [19:0] accAddr_d;
  logic [15:0] ackCnt_q, ackCnt_d;
  logic accTo_d;

  always_comb begin
    accBusy_d = accBusy_q;
    accKind_d = accKind_q;
    accAddr_d = accAddr_q;
    ackCnt_d = ackCnt_q;
    accTo_d = 1'b0;
    if (accStart) begin
      accBusy_d = 1'b1;
      accKind_d = accKind;
      accAddr_d = accAddr;
      ackCnt_d = 16'h0000;
    end else if (accBusy_q) begin
      // ready in the last waiting cycle still wins over the timeout
      if (busReady) begin
        accBusy_d = 1'b0;
      end else if (ackCnt_q == 16'(ACK_CYCLES - 1)) begin
        accBusy_d = 1'b0;
        accTo_d = 1'b1;
      end else begin
        ackCnt_d = ackCnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accBusy_q <= 1'b0;
      accKind_q <= 2'h0;
      accAddr_q <= 20'h00000;
      ackCnt_q <= 16'h0000;
      accTimeout <= 1'b0;
    end else begin
      accBusy_q <= accBusy_d;
      accKind_q <= accKind_d;
      accAddr_q <= accAddr_d;
      ackCnt_q <= ackCnt_d;
      accTimeout <= accTo_d;
    end
  end

  // timeout seen this cycle; address and kind still latched
  assign busTo = accTimeout;
  assign busToMem = accKind_q == ACC_USERMEM;

  // ==========================================================
  // cycle monitor, millisecond tick from a divider
  logic [15:0] divCnt_q, divCnt_d;
  logic [11:0] msCnt_q, msCnt_d;
  logic msTick, cycExpire, cycRestart;
  logic [11:0] cycLimitMs;

  assign msTick = divCnt_q == 16'(CYCLES_PER_MS - 1);
  // zero means unconfigured; widen first, as 2550 does not fit in eight bits
  always_comb begin
    if (cycLim_q == 8'h00) begin
      cycLimitMs = 12'(CYCLE_DEFAULT) * 12'(CYCLE_UNIT_MS);
    end else begin
      cycLimitMs = 12'(cycLim_q) * 12'(CYCLE_UNIT_MS);
    end
  end
  assign cycExpire = msTick && (msCnt_q + 12'h001 >= cycLimitMs);

  always_comb begin
    // the divider is cleared on restart too, so the first millisecond is a full one
    divCnt_d = msTick ? 16'h0000 : divCnt_q + 16'h0001;
    msCnt_d = msCnt_q;
    if (msTick) begin
      msCnt_d = msCnt_q + 12'h001;
    end
    if (mainCycleStart || cycleRetrigger || cycRestart || cycExpire) begin
      // restart at every main block start, retrigger, or expiry
      msCnt_d = 12'h000;
      divCnt_d = 16'h0000;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
      msCnt_q <= 12'h000;
    end else begin
      divCnt_q <= divCnt_d;
      msCnt_q <= msCnt_d;
    end
  end

  // ==========================================================
  // fault collection
  logic [9:0] newEv, pend_q, pend_d, take;
  logic isDist, blkSubst, blkMissing, overrunActive;
  logic osHard;

  // the gap between the two windows stays an ordinary direct access
  assign isDist = (accAddr_q >= DIST_A_LO && accAddr_q <= DIST_A_HI)
                  || accAddr_q >= DIST_B_LO;
  assign blkSubst = blockOpen && blockNum < 8'h02 && !blockIsExt;
  assign blkMissing = blockOpen && !blkSubst && !(blockExists && blockValid);
  assign osHard = memParityErr && memParityOsRam;

  // a halted unit keeps collecting events but dispatches none
  always_comb begin
    newEv = 10'h000;
    newEv[EV_PARITY] = (memParityErr && !memParityOsRam) || (busTo && busToMem);
    newEv[EV_CYCLE] = cycExpire && !overrunActive;
    newEv[EV_SUBST] = illegalSubst || illegalOpcode || blkSubst;
    newEv[EV_INTBYTE] = busTo && accKind_q == ACC_INTBYTE;
    // the access itself has completed before the fault is raised
    newEv[EV_ADDR] = imageAccessDone && !imageAssigned && chkOn_q;
    newEv[EV_DATABLK] = blkMissing;
    newEv[EV_LOGICBLK] = logicCallMissing;
    newEv[EV_DIRECT] = busTo && accKind_q == ACC_DIRECT && !isDist;
    newEv[EV_IMAGE] = busTo && accKind_q == ACC_IMAGE;
    newEv[EV_DIST] = busTo && accKind_q == ACC_DIRECT && isDist;
    // a new event wins over its own dispatch in the same cycle
    pend_d = (pend_q & ~take) | newEv;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 10'h000;
      blockRegsClear <= 1'b0;
    end else begin
      pend_q <= pend_d;
      blockRegsClear <= blkMissing || blkSubst;
    end
  end

  // ==========================================================
  // dispatcher with handler stack
  logic [3:0] stack_q [MAX_NEST];
  logic [3:0] stack_d [MAX_NEST];
  logic [2:0] depth_q, depth_d;
  logic halt_q, halt_d, hard_q, hard_d;
  logic call_d;
  logic [7:0] num_d;
  logic [3:0] sel;
  logic found;
  logic [4:0] ovCnt;

  // the stack keeps event indices, so a repeat overrun is seen while its handler runs
  // overrun handler still on the stack, counted per entry
  always_comb begin
    ovCnt = 5'h00;
    for (int i = 0; i < MAX_NEST; i++) begin
      if (3'(i) < depth_q && stack_q[i] == 4'(EV_CYCLE)) begin
        ovCnt = ovCnt + 5'h01;
      end
    end
  end
  assign overrunActive = ovCnt != 5'h00;

  always_comb begin
    sel = 4'h0;
    found = 1'b0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        sel = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_comb begin
    stack_d = stack_q;
    depth_d = depth_q;
    halt_d = halt_q;
    hard_d = hard_q;
    take = 10'h000;
    call_d = 1'b0;
    num_d = handlerNum;
    cycRestart = 1'b0;
    if (handlerDone && depth_q != 3'h0) begin
      depth_d = depth_q - 3'h1;
    end
    if (osHard) begin
      hard_d = 1'b1;
      halt_d = 1'b1;
    end else if (cycExpire && overrunActive) begin
      halt_d = 1'b1;
    end else if (found && !halt_q && !hard_q) begin
      take[sel] = 1'b1;
      if (!hEn_q[sel]) begin
        // absent handler: halt or carry on
        halt_d = HALT_IF_ABSENT[sel];
      end else if (depth_d == MAX_NEST) begin
        hard_d = 1'b1;
        halt_d = 1'b1;
      end else begin
        stack_d[depth_d] = sel;
        depth_d = depth_d + 3'h1;
        call_d = 1'b1;
        num_d = HANDLER_NUM[sel];
        cycRestart = sel == 4'(EV_CYCLE);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MAX_NEST; i++) begin
        stack_q[i] <= 4'h0;
      end
      depth_q <= 3'h0;
      halt_q <= 1'b0;
      hard_q <= 1'b0;
      handlerCall <= 1'b0;
      handlerNum <= 8'h00;
    end else begin
      stack_q <= stack_d;
      depth_q <= depth_d;
      halt_q <= halt_d;
      hard_q <= hard_d;
      handlerCall <= call_d;
      handlerNum <= num_d;
    end
  end

  assign nestDepth = depth_q;
  assign halted = halt_q;
  assign hardHalted = hard_q;
endmodule : plced_error_dispatch

// ==== verification/plced_backplane_model.sv ====
// Purpose: backplane modules answering accesses with ready
// Assumes: respDelay 0 means no module answers
// Notes: ready is a one-cycle pulse
module plced_backplane_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // access
  input wire logic accStart,
  input wire logic [7:0] respDelay,
  output logic busReady
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // an absent module stays silent so the watch must fire
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      busReady <= 1'b0;
    end else begin
      busReady <= (cnt == 1);
      if (accStart && respDelay != 8'h00) cnt <= respDelay;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule : plced_backplane_model

// ==== verification/plced_checker.sv ====
// Purpose: port checks on the dispatch unit
// Assumes: one clock, reset active high
// Notes: waitCnt mirrors the acknowledge watch
module plced_checker import plced_pkg::*; #(
  parameter int CYCLES_PER_MS = CYC_PER_MS,
  parameter int ACK_CYCLES = ACK_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // fault inputs
  input wire logic blockOpen,
  input wire logic blockRegsClear,
  input wire logic accStart,
  input wire logic busReady,
  input wire logic accTimeout,
  input wire logic illegalOpcode,
  input wire logic memParityErr,
  input wire logic memParityOsRam,
  // dispatch
  input wire logic handlerCall,
  input wire logic [7:0] handlerNum,
  input wire logic [2:0] nestDepth,
  input wire logic halted,
  input wire logic hardHalted
);
  timeunit 1ns;
  timeprecision 1ns;
  int waitCnt_q;
  int waitCnt_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ====
  // acknowledge watch
  always_comb begin
    waitCnt_d = 0;
    if (accStart) begin
      waitCnt_d = 1;
    end else if (waitCnt_q != 0 && !busReady && !accTimeout) begin
      waitCnt_d = waitCnt_q + 1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitCnt_q <= 0;
    end else begin
      waitCnt_q <= waitCnt_d;
    end
  end
  // ====
  // checks
  property p_tmo; accTimeout |-> waitCnt_q == ACK_CYCLES + 1; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout early");
  property p_due; waitCnt_q == ACK_CYCLES + 1 |-> accTimeout; endproperty
  a_due: assert property (p_due) else $error("timeout missing");
  property p_ack; busReady && waitCnt_q != 0 && waitCnt_q <= ACK_CYCLES |=> !accTimeout; endproperty
  a_ack: assert property (p_ack) else $error("timeout after ready");
  property p_clr; blockRegsClear |-> $past(blockOpen); endproperty
  a_clr: assert property (p_clr) else $error("clear without open");
  property p_sub; illegalOpcode && !halted && !hardHalted && nestDepth < MAX_NEST
    |-> ##[1:3] ((handlerCall && handlerNum == 8'h1B) || halted); endproperty
  a_sub: assert property (p_sub) else $error("opcode fault lost");
  property p_os; memParityErr && memParityOsRam |-> ##[1:3] hardHalted; endproperty
  a_os: assert property (p_os) else $error("no hard halt");
  property p_hard; hardHalted && $past(hardHalted) |-> !handlerCall; endproperty
  a_hard: assert property (p_hard) else $error("call while hard halted");
  property p_dep; handlerCall |-> nestDepth != 3'h0 && nestDepth <= MAX_NEST; endproperty
  a_dep: assert property (p_dep) else $error("bad depth");
  property p_rd; regRdata != 16'h0000 |-> $past(regRd); endproperty
  a_rd: assert property (p_rd) else $error("data without read");
endmodule : plced_checker
bind plced_error_dispatch plced_checker #(.CYCLES_PER_MS(CYCLES_PER_MS), .ACK_CYCLES(ACK_CYCLES))
  u_plced_checker (.clock, .rst, .regRd, .regRdata, .blockOpen, .blockRegsClear, .accStart, .busReady,
  .accTimeout, .illegalOpcode, .memParityErr, .memParityOsRam, .handlerCall, .handlerNum, .nestDepth,
  .halted, .hardHalted);

// ==== verification/tb_top.sv ====
// Purpose: directed tests of fault dispatch
// Assumes: one ms is 10 cycles here to keep runs short
// Notes: pulses bit k drives event input k
module tb_top import plced_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, accStart = 1'b0;
  logic blockExists = 1'b1, imageAssigned = 1'b1, memParityOsRam = 1'b0;
  logic busReady, blockRegsClear, accTimeout, handlerCall, halted, hardHalted;
  logic [10:0] pulses = '0;
  logic [19:0] regAddr = '0, accAddr = '0, base;
  logic [15:0] regWdata = '0, regRdata;
  logic [7:0] blockNum = 8'h20, handlerNum, respDelay = 8'h00;
  logic [1:0] accKind = 2'h0;
  logic [2:0] nestDepth;
  int mismatches = 0, check_count = 0, nCalls = 0, cycles = 0, n0;
  logic [19:0] toA [9] = '{20'h12345, 20'h34567, 20'h00100, 20'hF0010, 20'hFEFFF, 20'hFF200,
                           20'hFF1FF, 20'h0ABCD, 20'h22222};
  logic [1:0] toK [9] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
  logic [7:0] toN [9] = '{8'h17, 8'h18, 8'h1C, 8'h1D, 8'h1D, 8'h1D, 8'h17, 8'h1E, 8'h17};
  int evK [8] = '{0, 1, 2, 2, 3, 4, 5, 5};
  logic [1:0] evQ [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
  logic [7:0] evN [8] = '{8'h1B, 8'h1B, 8'h1B, 8'h13, 8'h13, 8'h19, 8'h1E, 8'h00};
  logic [1:0] evH [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h3};
  plced_error_dispatch #(.CYCLES_PER_MS(10)) u_plced_error_dispatch (
    .clock, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .blockOpen(pulses[2]), .blockIsExt(1'b0),
    .blockNum, .blockExists, .blockValid(1'b1), .logicCallMissing(pulses[3]), .blockRegsClear, .accStart,
    .accAddr, .accKind, .busReady, .accTimeout, .imageAccessDone(pulses[4]), .imageAssigned,
    .addrCheckOff(pulses[6]), .addrCheckOn(pulses[7]), .illegalSubst(pulses[1]), .illegalOpcode(pulses[0]),
    .memParityErr(pulses[5]), .memParityOsRam, .memParityAddr(20'h5A5A5), .mainCycleStart(pulses[8]),
    .cycleRetrigger(pulses[9]), .handlerDone(pulses[10]), .handlerCall, .handlerNum, .nestDepth, .halted,
    .hardHalted);
  plced_backplane_model u_plced_backplane_model (.clock, .rst, .accStart, .respDelay, .busReady);
  always #20 clock = ~clock;
  // ====
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // the ceiling is far above the longest path, so only a hang reaches it
  always @(posedge clock) begin
    cycles++;
    if (handlerCall === 1'b1) nCalls++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reset_dut();
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
  endtask : reset_dut
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk(regRdata, exp);
  endtask : rd
  task automatic ev(input int k, input logic [1:0] q);
    @(posedge clock);
    pulses <= 11'h001 << k;
    blockNum <= q[0] ? 8'h01 : 8'h20;
    blockExists <= !q[1];
    imageAssigned <= !q[0];
    memParityOsRam <= q[1];
    @(posedge clock);
    pulses <= '0;
  endtask : ev
  task automatic acc(input logic [19:0] a, input logic [1:0] k, input logic [7:0] d);
    @(posedge clock);
    accStart <= 1'b1;
    accAddr <= a;
    accKind <= k;
    respDelay <= d;
    @(posedge clock);
    accStart <= 1'b0;
  endtask : acc
  task automatic expCall(input logic [7:0] num, input int lim);
    int n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (handlerCall !== 1'b1 && n < lim);
    chk({7'h00, handlerCall, handlerNum}, {8'h01, num});
  endtask : expCall
  task automatic setup();
    reset_dut();
    wr(REG_HANDLER_EN, 16'h03FF);
    n0 = nCalls;
  endtask : setup
  // ====
  // tests
  initial begin
    setup();
    rd(REG_HANDLER_EN, 16'h03FF);
    rd(20'hEF0FF, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      acc(toA[i], toK[i], i == 8 ? 8'h28 : 8'h00);
      expCall(toN[i], 60);
      ev(10, 2'h0);
      base = toK[i] == 2'h3 ? REG_PAR_HI : REG_BUS_TO_HI;
      rd(base, {12'h000, toA[i][19:16]});
      rd(base + 20'h1, toA[i][15:0]);
    end
    n0 = nCalls;
    acc(20'h12345, 2'h0, 8'h27);
    repeat (50) @(negedge clock);
    chk(16'(nCalls - n0), 16'h0000);
    wr(REG_BUS_TO_HI, 16'hFFFF);
    rd(REG_BUS_TO_HI, 16'h0002);
    $display("test timeouts finished");
    for (int i = 0; i < 7; i++) begin
      ev(evK[i], evQ[i]);
      expCall(evN[i], 8);
      ev(10, 2'h0);
      if (evN[i] == 8'h13) rd(REG_FAULT_TYPE, evK[i] == 2 ? TYPE_DATA_MISSING : TYPE_LOGIC_MISSING);
    end
    rd(REG_PAR_HI, 16'h0005);
    rd(REG_PAR_LO, 16'hA5A5);
    for (int i = 0; i < 8; i++) begin
      reset_dut();
      ev(evK[i], evQ[i]);
      @(negedge clock);
      chk({15'h0000, blockRegsClear}, {15'h0000, evK[i] == 2});
      repeat (3) @(negedge clock);
      chk({14'h0000, hardHalted, halted}, {14'h0000, evH[i]});
    end
    $display("test events finished");
    setup();
    repeat (5) ev(0, 2'h0);
    repeat (3) @(negedge clock);
    chk({12'h000, hardHalted, nestDepth}, 16'h0005);
    rd(REG_STATUS, 16'h002C);
    ev(0, 2'h0);
    repeat (4) @(negedge clock);
    chk({15'h0000, hardHalted}, 16'h0001);
    rd(REG_STATUS, 16'h002F);
    setup();
    ev(6, 2'h0);
    ev(4, 2'h1);
    repeat (6) @(negedge clock);
    chk(16'(nCalls - n0), 16'h0000);
    ev(7, 2'h0);
    ev(4, 2'h1);
    expCall(8'h19, 8);
    $display("test nesting finished");
    setup();
    ev(8, 2'h0);
    repeat (1900) @(negedge clock);
    chk(16'(nCalls - n0), 16'h0000);
    expCall(8'h1A, 200);
    setup();
    wr(REG_CYCLE_LIMIT, 16'h0001);
    ev(8, 2'h0);
    repeat (4) begin
      repeat (60) @(posedge clock);
      ev(9, 2'h0);
    end
    chk(16'(nCalls - n0), 16'h0000);
    expCall(8'h1A, 130);
    repeat (130) @(negedge clock);
    chk({15'h0000, halted}, 16'h0001);
    setup();
    wr(REG_CYCLE_LIMIT, 16'h001A);
    ev(8, 2'h0);
    repeat (2500) @(negedge clock);
    chk(16'(nCalls - n0), 16'h0000);
    expCall(8'h1A, 200);
    $display("test cycle finished");
    end_of_test();
  end
endmodule : tb_top
